// file: bench/tstc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host processor on the control bus
// ----------------------------------------
module tstc_host
    import tstc_pkg::*;
(
    // bus pins
    input  wire logic        clk,
    output tstc_req_t        req,
    input  wire logic [31:0] rdata,
    input  wire logic        ack,
    input  wire logic        err_n
);
    // one strobe, then a bounded wait for ack or error; r = {ack, error}
    task automatic acc(input logic w, input logic [23:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic [1:0] r);
        int i;
        @(posedge clk);
        req <= '{1'b1, w, a, d};
        @(posedge clk);
        req.sel <= 1'b0;
        for (i = 0; i < 6; i++) begin
            #1;
            if (ack === 1'b1 || err_n === 1'b0) break;
            @(posedge clk);
        end
        r = {ack === 1'b1, err_n === 1'b0};
        q = rdata;
    endtask
    initial req = '0;
endmodule
`default_nettype wire

// file: bench/tstc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tstc_top_bench
    import tstc_pkg::*;
;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             tk = 1'b0;
    logic             ft = 1'b0;
    logic             fs = 1'b0;
    logic [2:0]       dv = 3'h0;
    logic [3:0]       ock, ofr;
    logic [31:0]      git, got;
    logic [31:0][2:0] adv;
    logic [1:0]       rate = 2'h0;
    tstc_lanes_t      sin = '0;
    tstc_lanes_t      oraw = '1;
    tstc_lanes_t      sout, idat;
    tstc_req_t        req;
    logic [31:0]      rd, gs, q;
    logic [31:0][4:0] sd;
    logic [14:0]      dma;
    logic [9:0]       dmt;
    logic [1:0]       dms, r;
    logic             ack, err_n, dmr;
    logic [26:0]      cap;
    int               n_errors = 0;
    int               n_tests = 0;
    always #2 clk = ~clk;
    // free toggling timing source, driven on the sampling edge
    always @(posedge clk) tk <= ~tk;
    // slow reference clock, so that the three-stage filter lets it through
    always @(posedge clk) dv <= dv + 3'h1;
    // capture the memory port when the read strobe shows
    always @(posedge clk) if (dmr === 1'b1) cap <= {dms, dmt, dma};
    tstc_host host_u (.clk(clk), .req(req), .rdata(rd), .ack(ack),
        .err_n(err_n));
    tstc_top dut_u (.clk(clk), .rst_n(rst_n), .host_req(req),
        .bus_rdata_q(rd), .bus_ack_q(ack), .bus_error_n(err_n),
        .global_rate_sel(rate), .dm_rd_q(dmr), .dm_addr_q(dma),
        .dm_stream_q(dms), .dm_slot_q(dmt), .dm_rdata(8'h3c),
        .sys_bit_tick(tk), .int_ref_clock(tk), .int_frame_start(fs),
        .frame_tick(ft), .ref_clock_0(dv[2]), .ref_clock_1(dv[2]),
        .ref_clock_2(dv[2]), .ref_frame_0(1'b0), .ref_frame_1(1'b0),
        .ref_frame_2(1'b0), .ref_edge_q(), .ref_frame_start_q(),
        .serial_in(sin), .in_data_q(idat), .out_raw(oraw),
        .serial_out_q(sout), .grp_in_tick_q(git), .grp_out_tick_q(got),
        .in_sample_delay_q(sd), .out_advance_cyc_q(adv),
        .group_settling_q(gs), .out_clock_q(ock), .out_frame_q(ofr));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // every group register, then both reference registers
    task automatic t_regs;
        logic [31:0] a, d;
        host_u.acc(1'b0, 24'h040214, 32'h0, q, r);
        chk(q, 32'h000c000c);
        for (int n = 0; n < 34; n++) begin
            a = 32'h040200 + 32'(4 * n);
            d = 32'h000c000c | (32'(n) << 4);
            if (n > 31) d = (n == 32) ? 32'h1ff : 32'h0f9f3e7c;
            host_u.acc(1'b1, a[23:0], d, q, r);
            host_u.acc(1'b0, a[23:0], 32'h0, q, r);
            chk(q, d);
        end
    endtask
    // memory write, high offset at lowest rate, unaligned, unmapped
    task automatic t_errs;
        logic [24:0] e [4] = '{25'h1028000, 25'h028200, 25'h040202,
                               25'h040288};
        for (int i = 0; i < 4; i++) begin
            host_u.acc(e[i][24], e[i][23:0], 32'h0, q, r);
            chk(32'(r), 32'h1);
        end
    endtask
    // last slot of stream d at lowest rate, then offset 200 at rate 01
    task automatic t_dmem;
        host_u.acc(1'b0, 24'h0285ff, 32'h0, q, r);
        chk({r, q[29:0]}, 32'h8000003c);
        chk(32'(cap), 32'({2'd3, 10'h07f, 5'd1, 10'h1ff}));
        rate <= 2'h1;
        host_u.acc(1'b0, 24'h028200, 32'h0, q, r);
        chk(32'(cap), 32'({2'd2, 10'h000, 5'd0, 10'h200}));
    endtask
    // inversion, sample delay, advance and the two-frame settle of group 2
    task automatic t_stream;
        host_u.acc(1'b1, 24'h040208, 32'h006c02fc, q, r);
        chk(32'(gs[2]), 32'h1);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ft <= 1'b1;
            @(posedge clk);
            ft <= 1'b0;
            repeat (6) @(posedge clk);
            #1;
            chk(32'(gs[2]), 32'(k == 0));
        end
        chk(32'(adv[2]), 32'h3);
        chk(32'(sout.lane_a[2:1]), 32'h1);
        chk(32'(idat.lane_d[2:1]), 32'h2);
        chk(32'(sd[2]), 32'h0f);
    endtask
    // top rate gci pulse, active low, on all four sets; ticks and clocks
    task automatic t_oref;
        chk(git, {32{~tk}});
        chk(got, {32{~tk}});
        chk(32'(ock), 32'({4{tk}}));
        @(posedge clk);
        fs <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            #1;
            chk(32'(ofr), (c % 4 == 0) ? 32'hf : 32'h0);
            @(posedge clk);
        end
    endtask
    task automatic end_of_test;
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_errs;
        t_dmem;
        t_stream;
        t_oref;
        end_of_test;
    end
    // watchdog at 25000 cycles, well past the expected few hundred cycles
    initial begin
        #100000;
        n_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire

// file: hdl/tstc_addr_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "tstc_cfg.svh"
module tstc_addr_dec
    import tstc_pkg::*;
(
    // host byte address in, target out
    input  wire logic [23:0] addr,
    output tstc_dec_t        dec
);

    // unaligned register addresses fall through to none
    always_comb begin
        dec      = '0;
        dec.kind = DK_NONE;
        if (addr >= `TSTC_DM_BASE && addr <= `TSTC_DM_END) begin
            dec.kind = DK_DMEM;
            dec.grp  = addr[14:10];
            dec.ofs  = addr[9:0];
        end else if (addr >= `TSTC_GRP_BASE && addr <= `TSTC_GRP_LAST
                     && addr[1:0] == 2'h0) begin
            dec.kind = DK_GRP;
            dec.grp  = addr[6:2];
        end else if (addr == `TSTC_IREF_ADDR) begin
            dec.kind = DK_IREF;
        end else if (addr == `TSTC_OREF_ADDR) begin
            dec.kind = DK_OREF;
        end
    end

endmodule
`default_nettype wire

// file: hdl/tstc_cfg.svh
`ifndef TSTC_CFG_SVH
`define TSTC_CFG_SVH

// ------------------------------------------------------------
// address map (byte addresses)
// ------------------------------------------------------------
`define TSTC_DM_BASE      24'h028000
`define TSTC_DM_END       24'h02ffff
`define TSTC_DM_LOW_LIMIT 10'h200
`define TSTC_GRP_BASE     24'h040200
`define TSTC_GRP_LAST     24'h04027c
`define TSTC_IREF_ADDR    24'h040280
`define TSTC_OREF_ADDR    24'h040284

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TSTC_GRP_RST      32'h000c000c
`define TSTC_IREF_RST     32'h00000000
`define TSTC_OREF_RST     32'h00000000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TSTC_OINV_BIT     22
`define TSTC_OADV_LSB     20
`define TSTC_OSRC_LSB     16
`define TSTC_IINV_BIT     9
`define TSTC_IDLY_LSB     4
`define TSTC_ISRC_LSB     0
`define TSTC_IREF_SET_W   3
`define TSTC_OREF_SET_W   7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TSTC_CLK_PS       4000
`define TSTC_ADV_STEP_PS  7600
`define TSTC_FP_NS0       120
`define TSTC_FP_NS1       60
`define TSTC_FP_NS2       30
`define TSTC_FP_NS3       15
`define TSTC_SETTLE_FRAMES 2'd2

`endif

// file: hdl/tstc_pkg.sv
package tstc_pkg;

    // decoded target of a host access
    typedef enum logic [2:0] {
        DK_NONE,
        DK_DMEM,
        DK_GRP,
        DK_IREF,
        DK_OREF
    } tstc_kind_t;

    typedef struct packed {
        tstc_kind_t  kind;
        logic [4:0]  grp;
        logic [9:0]  ofs;
    } tstc_dec_t;

    // host request, a one-cycle strobe with its fields
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [23:0] addr;
        logic [31:0] wdata;
    } tstc_req_t;

    // one bit per group for each of the four streams
    typedef struct packed {
        logic [31:0] lane_a;
        logic [31:0] lane_b;
        logic [31:0] lane_c;
        logic [31:0] lane_d;
    } tstc_lanes_t;

    typedef enum logic {
        BS_IDLE,
        BS_DMRD
    } tstc_bus_st_t;

endpackage

// file: hdl/tstc_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module tstc_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins in, filtered level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
        end
    end

endmodule
`default_nettype wire

// file: hdl/tstc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tstc_cfg.svh"
// Contract
// - data memory address is group base plus stream offset, linear slots
// - lowest rate: streams at 000/080/100/180; 200-3FF gives bus error
// - data memory is read only; writes answered with bus error low
// - groups of four inputs and four outputs, each side configured apart
// - 32 group registers at 40200 plus 4n, last at 4027C
// - group bit 22 inverts that group's output streams
// - 2-bit output advance, step 7.6 ns, halved at highest rate
// - source code 00 internal, 01-11 select reference pairs 0-2
// - group bit 9 inverts that group's input streams
// - 5-bit input sample delay in bits 8-4, default at 3/4 cell
// - group may be disturbed at most two frames after a change
// - input reference register at 40280: edge, polarity, format per input
// - input frame format bit selects native or GCI-Bus framing
// - input frame polarity bit: low active high, high active low
// - input clock edge bit: low positive edge, high negative edge
// - output reference register at 40284, four 7-bit sets
// - output frame format bit selects native or GCI-Bus framing
// - output frame polarity bit: low active high, high active low
// - rate codes give 120/60/30/15 ns pulses; host limits rate by source; the 4 ns clock gives 120/60/28/12 ns
// - output clock edge bit: low positive, high negative
// - one global rate field, zero after power-up selects lowest rate
module tstc_top
    import tstc_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // host control bus
    input  wire tstc_req_t    host_req,
    output logic [31:0]       bus_rdata_q,
    output logic              bus_ack_q,
    output logic              bus_error_n,
    // global rate from the rate register
    input  wire logic [1:0]   global_rate_sel,
    // data memory read port
    output logic              dm_rd_q,
    output logic [14:0]       dm_addr_q,
    output logic [1:0]        dm_stream_q,
    output logic [9:0]        dm_slot_q,
    input  wire logic [7:0]   dm_rdata,
    // internal timing, same clock
    input  wire logic         sys_bit_tick,
    input  wire logic         int_ref_clock,
    input  wire logic         int_frame_start,
    input  wire logic         frame_tick,
    // reference pins
    input  wire logic         ref_clock_0,
    input  wire logic         ref_clock_1,
    input  wire logic         ref_clock_2,
    input  wire logic         ref_frame_0,
    input  wire logic         ref_frame_1,
    input  wire logic         ref_frame_2,
    output logic [2:0]        ref_edge_q,
    output logic [2:0]        ref_frame_start_q,
    // stream data
    input  wire tstc_lanes_t  serial_in,
    output tstc_lanes_t       in_data_q,
    input  wire tstc_lanes_t  out_raw,
    output tstc_lanes_t       serial_out_q,
    // per-group timing
    output logic [31:0]       grp_in_tick_q,
    output logic [31:0]       grp_out_tick_q,
    output logic [31:0][4:0]  in_sample_delay_q,
    output logic [31:0][2:0]  out_advance_cyc_q,
    output logic [31:0]       group_settling_q,
    // output reference pins
    output logic [3:0]        out_clock_q,
    output logic [3:0]        out_frame_q
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] stream_of(input logic [1:0] r,
                                             input logic [9:0] o);
        case (r)
            2'h0:    stream_of = o[8:7];
            2'h1:    stream_of = o[9:8];
            2'h2:    stream_of = {1'b0, o[9]};
            default: stream_of = 2'h0;
        endcase
    endfunction

    function automatic logic [9:0] slot_of(input logic [1:0] r,
                                           input logic [9:0] o);
        case (r)
            2'h0:    slot_of = {3'h0, o[6:0]};
            2'h1:    slot_of = {2'h0, o[7:0]};
            2'h2:    slot_of = {1'b0, o[8:0]};
            default: slot_of = o;
        endcase
    endfunction

    // source 00 is internal timing, else reference pair src-1
    function automatic logic pick(input logic [1:0] src,
                                  input logic       int_v,
                                  input logic [2:0] ref_v);
        pick = (src == 2'h0) ? int_v : ref_v[src - 2'h1];
    endfunction

    // advance rounded down to whole clocks; half step at top rate
    function automatic logic [2:0] adv_cyc(input logic [1:0] code,
                                           input logic [1:0] r);
        int ps;
        ps = int'(code) * `TSTC_ADV_STEP_PS;
        if (r == 2'h3)
            ps = ps / 2;
        adv_cyc = 3'(ps / `TSTC_CLK_PS);
    endfunction

    // frame pulse width in clocks, rounded down
    function automatic logic [5:0] fp_cyc(input logic [1:0] r);
        case (r)
            2'h0:    fp_cyc = 6'(`TSTC_FP_NS0 * 1000 / `TSTC_CLK_PS);
            2'h1:    fp_cyc = 6'(`TSTC_FP_NS1 * 1000 / `TSTC_CLK_PS);
            2'h2:    fp_cyc = 6'(`TSTC_FP_NS2 * 1000 / `TSTC_CLK_PS);
            default: fp_cyc = 6'(`TSTC_FP_NS3 * 1000 / `TSTC_CLK_PS);
        endcase
    endfunction

    // ------------------------------------------------------------
    // decode and bus state
    // ------------------------------------------------------------
    tstc_dec_t    dec;
    tstc_bus_st_t bus_st_q;
    logic [31:0]  grp_cfg_q [32];
    logic [31:0]  iref_q;
    logic [31:0]  oref_q;
    logic         take;
    logic         wr_grp;
    logic         dm_blocked;

    tstc_addr_dec u_dec (
        .addr (host_req.addr),
        .dec  (dec)
    );

    assign take   = host_req.sel && bus_st_q == BS_IDLE;
    assign wr_grp = take && host_req.wr && dec.kind == DK_GRP;
    assign dm_blocked = global_rate_sel == 2'h0 &&
                        dec.ofs >= `TSTC_DM_LOW_LIMIT;

    // one request at a time; strobes during a memory read are dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_st_q    <= BS_IDLE;
            bus_ack_q   <= 1'b0;
            bus_error_n <= 1'b1;
            bus_rdata_q <= 32'h0;
            dm_rd_q     <= 1'b0;
            dm_addr_q   <= 15'h0;
            dm_stream_q <= 2'h0;
            dm_slot_q   <= 10'h0;
        end else begin
            bus_ack_q   <= 1'b0;
            bus_error_n <= 1'b1;
            dm_rd_q     <= 1'b0;
            case (bus_st_q)
                BS_IDLE: begin
                    if (take) begin
                        case (dec.kind)
                            DK_DMEM: begin
                                if (host_req.wr || dm_blocked) begin
                                    bus_error_n <= 1'b0;
                                end else begin
                                    dm_rd_q     <= 1'b1;
                                    dm_addr_q   <= {dec.grp, dec.ofs};
                                    dm_stream_q <= stream_of(
                                        global_rate_sel, dec.ofs);
                                    dm_slot_q   <= slot_of(
                                        global_rate_sel, dec.ofs);
                                    bus_st_q    <= BS_DMRD;
                                end
                            end
                            DK_GRP: begin
                                bus_ack_q <= 1'b1;
                                if (!host_req.wr)
                                    bus_rdata_q <= grp_cfg_q[dec.grp];
                            end
                            DK_IREF: begin
                                bus_ack_q <= 1'b1;
                                if (!host_req.wr)
                                    bus_rdata_q <= iref_q;
                            end
                            DK_OREF: begin
                                bus_ack_q <= 1'b1;
                                if (!host_req.wr)
                                    bus_rdata_q <= oref_q;
                            end
                            default: bus_error_n <= 1'b0;
                        endcase
                    end
                end
                BS_DMRD: begin
                    bus_rdata_q <= {24'h0, dm_rdata};
                    bus_ack_q   <= 1'b1;
                    bus_st_q    <= BS_IDLE;
                end
                default: bus_st_q <= BS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // stored whole, reserved bits included, so software sees its value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int g = 0; g < 32; g++)
                grp_cfg_q[g] <= `TSTC_GRP_RST;
            iref_q <= `TSTC_IREF_RST;
            oref_q <= `TSTC_OREF_RST;
        end else if (take && host_req.wr) begin
            if (dec.kind == DK_GRP)
                grp_cfg_q[dec.grp] <= host_req.wdata;
            if (dec.kind == DK_IREF)
                iref_q <= host_req.wdata;
            if (dec.kind == DK_OREF)
                oref_q <= host_req.wdata;
        end
    end

    // a write restarts the two-frame settle window of its group
    logic [1:0] settle_q [32];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int g = 0; g < 32; g++)
                settle_q[g] <= 2'h0;
            group_settling_q <= 32'h0;
        end else begin
            for (int g = 0; g < 32; g++) begin
                if (wr_grp && dec.grp == 5'(g)) begin
                    settle_q[g]         <= `TSTC_SETTLE_FRAMES;
                    group_settling_q[g] <= 1'b1;
                end else if (frame_tick && settle_q[g] != 2'h0) begin
                    settle_q[g]         <= settle_q[g] - 2'h1;
                    group_settling_q[g] <= settle_q[g] != 2'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // reference inputs
    // ------------------------------------------------------------
    logic [2:0] rclk_s;
    logic [2:0] rfp_s;
    logic [2:0] rclk_prev_q;
    logic [2:0] fp_act;
    logic [2:0] fp_prev_q;

    tstc_sync3 #(.W(6)) u_ref_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({ref_frame_2, ref_frame_1, ref_frame_0,
                 ref_clock_2, ref_clock_1, ref_clock_0}),
        .q     ({rfp_s, rclk_s})
    );

    always_comb begin
        for (int k = 0; k < 3; k++)
            fp_act[k] = rfp_s[k] ^ iref_q[3 * k + 1];
    end

    // native pulses straddle the boundary, so their trailing edge marks it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rclk_prev_q       <= 3'h0;
            fp_prev_q         <= 3'h0;
            ref_edge_q        <= 3'h0;
            ref_frame_start_q <= 3'h0;
        end else begin
            rclk_prev_q <= rclk_s;
            fp_prev_q   <= fp_act;
            for (int k = 0; k < 3; k++) begin
                ref_edge_q[k] <= iref_q[3 * k] ?
                    (rclk_prev_q[k] & ~rclk_s[k]) :
                    (rclk_s[k] & ~rclk_prev_q[k]);
                ref_frame_start_q[k] <= iref_q[3 * k + 2] ?
                    (fp_act[k] & ~fp_prev_q[k]) :
                    (fp_prev_q[k] & ~fp_act[k]);
            end
        end
    end

    // ------------------------------------------------------------
    // per-group timing and data
    // ------------------------------------------------------------
    tstc_lanes_t ser_s;
    logic [31:0] in_inv;
    logic [31:0] out_inv;

    tstc_sync3 #(.W(128)) u_ser_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (serial_in),
        .q     (ser_s)
    );

    always_comb begin
        for (int g = 0; g < 32; g++) begin
            in_inv[g]  = grp_cfg_q[g][`TSTC_IINV_BIT];
            out_inv[g] = grp_cfg_q[g][`TSTC_OINV_BIT];
        end
    end

    // one configuration bit covers all four lanes of a group
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_data_q    <= '0;
            serial_out_q <= '0;
        end else begin
            in_data_q.lane_a    <= ser_s.lane_a ^ in_inv;
            in_data_q.lane_b    <= ser_s.lane_b ^ in_inv;
            in_data_q.lane_c    <= ser_s.lane_c ^ in_inv;
            in_data_q.lane_d    <= ser_s.lane_d ^ in_inv;
            serial_out_q.lane_a <= out_raw.lane_a ^ out_inv;
            serial_out_q.lane_b <= out_raw.lane_b ^ out_inv;
            serial_out_q.lane_c <= out_raw.lane_c ^ out_inv;
            serial_out_q.lane_d <= out_raw.lane_d ^ out_inv;
        end
    end

    // delay 0 keeps the default three-quarter sample point downstream
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            grp_in_tick_q     <= 32'h0;
            grp_out_tick_q    <= 32'h0;
            in_sample_delay_q <= '0;
            out_advance_cyc_q <= '0;
        end else begin
            for (int g = 0; g < 32; g++) begin
                grp_in_tick_q[g] <= pick(grp_cfg_q[g][1:0],
                    sys_bit_tick, ref_edge_q);
                grp_out_tick_q[g] <= pick(grp_cfg_q[g][17:16],
                    sys_bit_tick, ref_edge_q);
                in_sample_delay_q[g] <=
                    grp_cfg_q[g][`TSTC_IDLY_LSB +: 5];
                out_advance_cyc_q[g] <= adv_cyc(
                    grp_cfg_q[g][`TSTC_OADV_LSB +: 2],
                    global_rate_sel);
            end
        end
    end

    // ------------------------------------------------------------
    // output reference sets
    // ------------------------------------------------------------
    logic [5:0] ofp_cnt_q [4];
    logic [5:0] ofp_cnt_d [4];
    logic [3:0] ofp_act_d;

    // GCI pulses start half a width later than native ones
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ofp_cnt_d[k] = ofp_cnt_q[k];
            if (pick(oref_q[7 * k +: 2], int_frame_start,
                     ref_frame_start_q)) begin
                ofp_cnt_d[k] = fp_cyc(oref_q[7 * k + 2 +: 2]);
                if (oref_q[7 * k + 6])
                    ofp_cnt_d[k] = ofp_cnt_d[k] +
                        (ofp_cnt_d[k] >> 1);
            end else if (ofp_cnt_q[k] != 6'h0) begin
                ofp_cnt_d[k] = ofp_cnt_q[k] - 6'h1;
            end
            ofp_act_d[k] = ofp_cnt_d[k] != 6'h0 &&
                ofp_cnt_d[k] <= fp_cyc(oref_q[7 * k + 2 +: 2]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int k = 0; k < 4; k++)
                ofp_cnt_q[k] <= 6'h0;
            out_clock_q <= 4'h0;
            out_frame_q <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                ofp_cnt_q[k]   <= ofp_cnt_d[k];
                out_clock_q[k] <= pick(oref_q[7 * k +: 2],
                    int_ref_clock, rclk_s) ^ oref_q[7 * k + 4];
                out_frame_q[k] <= ofp_act_d[k] ^
                    oref_q[7 * k + 5];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_dm_write_err: assert property (@(posedge clk) disable iff (!rst_n)
        take && host_req.wr && dec.kind == DK_DMEM
        |=> !bus_error_n && !bus_ack_q && !dm_rd_q)
        else $error("data memory write not refused");

    a_dm_low_rate: assert property (@(posedge clk) disable iff (!rst_n)
        take && dec.kind == DK_DMEM && global_rate_sel == 2'h0
        && dec.ofs >= 10'h200 |=> !bus_error_n)
        else $error("high offset at lowest rate not refused");

    a_dm_read_seq: assert property (@(posedge clk) disable iff (!rst_n)
        take && !host_req.wr && dec.kind == DK_DMEM && !dm_blocked
        |=> dm_rd_q && !bus_ack_q ##1 bus_ack_q && bus_error_n)
        else $error("data memory read sequence wrong");

    a_dm_addr_lin: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dm_rd_q) |-> dm_addr_q ==
        {$past(host_req.addr[14:10]), $past(host_req.addr[9:0])})
        else $error("data memory address not linear");

    a_dm_stream: assert property (@(posedge clk) disable iff (!rst_n)
        dm_rd_q && $past(global_rate_sel) == 2'h0 |->
        dm_stream_q == dm_addr_q[8:7] && dm_slot_q[9:7] == 3'h0)
        else $error("stream split wrong at lowest rate");

    a_grp_readback: assert property (@(posedge clk) disable iff (!rst_n)
        take && host_req.wr && dec.kind == DK_GRP ##1 !take ##1
        take && !host_req.wr && host_req.addr == $past(host_req.addr, 2)
        |=> bus_ack_q && bus_rdata_q == $past(host_req.wdata, 3))
        else $error("group register readback differs");

    a_out_invert: assert property (@(posedge clk) disable iff (!rst_n)
        $stable(out_inv) |=> serial_out_q.lane_a ==
        ($past(out_raw.lane_a) ^ $past(out_inv)))
        else $error("output inversion wrong");

    a_settle_set: assert property (@(posedge clk) disable iff (!rst_n)
        wr_grp |=> group_settling_q[$past(dec.grp)])
        else $error("settle window not started");

    a_ref_pos_edge: assert property (@(posedge clk) disable iff (!rst_n)
        !iref_q[0] && $stable(iref_q) && rclk_s[0] && !rclk_prev_q[0]
        |=> ref_edge_q[0])
        else $error("positive reference edge missed");

endmodule
`default_nettype wire
